// ---- rsc_top.sv ----
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rsc_top (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [3:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   output logic              wb_err_o,
   // Reset sources, wake events and watchdog fuse
   input  wire logic         por_req_i,
   input  wire logic         brownout_req_i,
   input  wire logic         master_clear_pin_n_i,
   input  wire logic         soft_reset_req_i,
   input  wire logic         watchdog_timeout_i,
   input  wire logic         trap_conflict_i,
   input  wire rsc_pkg::rsc_illegal_t illegal_i,
   input  wire rsc_pkg::rsc_wake_t    wake_i,
   input  wire logic         watchdog_fuse_enable_i,
   // Outputs
   output logic              master_reset_out_o,
   output logic              watchdog_enable_o,
   output logic              regulator_sleep_active_o
);

   // ***************************************************
   // Source conditioning
   // ***************************************************
   logic        pin_sync;
   logic        fuse_sync;
   logic [rsc_pkg::NUM_SRC-1:0] req;
   logic [rsc_pkg::NUM_SRC-1:0] rise;
   logic        any_req;

   // The pin and fuse come from outside the clock domain
   rsc_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({~master_clear_pin_n_i, watchdog_fuse_enable_i}),
      .q_o   ({pin_sync, fuse_sync})
   );

   // Source vector in fixed index order
   assign req[rsc_pkg::SRC_POR]  = por_req_i;
   assign req[rsc_pkg::SRC_BOR]  = brownout_req_i;
   assign req[rsc_pkg::SRC_PIN]  = pin_sync;
   assign req[rsc_pkg::SRC_SWR]  = soft_reset_req_i;
   assign req[rsc_pkg::SRC_WDT]  = watchdog_timeout_i;
   assign req[rsc_pkg::SRC_TRAP] = trap_conflict_i;
   assign req[rsc_pkg::SRC_ILL]  = |illegal_i;

   rsc_combine #(
      .NUM (rsc_pkg::NUM_SRC)
   ) u_comb (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .req_i  (req),
      .any_o  (any_req),
      .rise_o (rise)
   );

   // ***************************************************
   // Master reset
   // ***************************************************
   logic mrst_q;

   // Registered so the output is glitch free; one cycle of latency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mrst_q <= 1'b1;
      end else begin
         mrst_q <= any_req;
      end
   end

   assign master_reset_out_o = mrst_q;

   // ***************************************************
   // Bus decode
   // ***************************************************
   logic        ack_q;
   logic        err_q;
   logic [31:0] rdat_q;
   wire         req_acc  = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
   wire         sel_cause = (wb_adr_i == rsc_pkg::REG_CAUSE_OFS);
   wire         sel_src   = (wb_adr_i == rsc_pkg::REG_SRC_OFS);
   wire         sel_ctrl  = (wb_adr_i == rsc_pkg::REG_CTRL_OFS);
   wire         mapped    = sel_cause | sel_src | sel_ctrl;
   wire         wr_cause  = req_acc & wb_we_i & sel_cause;
   wire         wr_ctrl   = req_acc & wb_we_i & sel_ctrl;

   // Byte lane write mask over the low half word
   wire [15:0]  lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // ***************************************************
   // Reset cause register
   // ***************************************************
   logic [15:0] cause_q;
   logic [15:0] cause_d;
   logic [15:0] set_vec;
   logic [15:0] wr_val;

   // Hardware set events, one per flag
   always_comb begin
      set_vec = 16'h0000;
      set_vec[rsc_pkg::POR_BIT]   = rise[rsc_pkg::SRC_POR];
      set_vec[rsc_pkg::BOR_BIT]   = rise[rsc_pkg::SRC_BOR];
      set_vec[rsc_pkg::PIN_RESET_FLAG_BIT]  = rise[rsc_pkg::SRC_PIN];
      set_vec[rsc_pkg::SWR_BIT]   = rise[rsc_pkg::SRC_SWR];
      set_vec[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT]  = rise[rsc_pkg::SRC_WDT];
      set_vec[rsc_pkg::TRAP_BIT]  = rise[rsc_pkg::SRC_TRAP];
      set_vec[rsc_pkg::ILL_BIT]   = rise[rsc_pkg::SRC_ILL];
      set_vec[rsc_pkg::SLEEP_BIT] = wake_i.sleep;
      set_vec[rsc_pkg::IDLE_BIT]  = wake_i.idle;
   end

   // Software value merged by byte lane; plain storage, no reset side effect
   assign wr_val = wr_cause ? ((wb_dat_i[15:0] & lane_mask) | (cause_q & ~lane_mask))
                            : cause_q;

   // Power-on wipes all but its own flag; other events only add (set wins)
   always_comb begin
      if (rise[rsc_pkg::SRC_POR]) begin
         cause_d = ((cause_q & rsc_pkg::POR_KEEP) | set_vec) & rsc_pkg::CAUSE_MASK;
      end else begin
         cause_d = (wr_val | set_vec) & rsc_pkg::CAUSE_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_q <= rsc_pkg::CAUSE_RESET;
      end else begin
         cause_q <= cause_d;
      end
   end

   // ***************************************************
   // Watchdog and regulator controls
   // ***************************************************
   // Fuse left unprogrammed forces the watchdog on
   assign watchdog_enable_o = fuse_sync | cause_q[rsc_pkg::SWDT_BIT];
   // High keeps the regulator active during sleep
   assign regulator_sleep_active_o = cause_q[rsc_pkg::VREG_BIT];

   // ***************************************************
   // Control register: spare scratch byte
   // ***************************************************
   logic [7:0] ctrl_q;

   // Scratch control byte, kept for firmware handshakes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= 8'h00;
      end else if (wr_ctrl && wb_sel_i[0]) begin
         ctrl_q <= wb_dat_i[7:0];
      end
   end

   // ***************************************************
   // Bus answer
   // ***************************************************
   wire [31:0] rd_mux = sel_cause ? {16'h0000, cause_q & rsc_pkg::CAUSE_MASK} :
                        sel_src   ? {24'h000000, 1'b0, req} :
                        sel_ctrl  ? {24'h000000, ctrl_q} :
                                    32'h00000000;

   // One-cycle answer; unmapped addresses get err
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         err_q  <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q  <= req_acc & mapped;
         err_q  <= req_acc & ~mapped;
         rdat_q <= req_acc ? rd_mux : rdat_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = rdat_q;

endmodule : rsc_top

`default_nettype wire

// ---- rsc_pkg.sv ----
package rsc_pkg;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [3:0]  REG_CAUSE_OFS   = 4'h0;   // Reset cause register, byte address
   localparam logic [3:0]  REG_SRC_OFS     = 4'h4;   // Live source levels, read only
   localparam logic [3:0]  REG_CTRL_OFS    = 4'h8;   // Spare scratch control byte

   // ***************************************************
   // Field positions in the reset cause register
   // ***************************************************
   localparam int POR_BIT   = 0;
   localparam int BOR_BIT   = 1;
   localparam int IDLE_BIT  = 2;
   localparam int SLEEP_BIT = 3;
   localparam int WATCHDOG_TIMEOUT_FLAG_BIT  = 4;
   localparam int SWDT_BIT  = 5;
   localparam int SWR_BIT   = 6;
   localparam int PIN_RESET_FLAG_BIT  = 7;
   localparam int VREG_BIT  = 8;
   localparam int ILL_BIT   = 14;
   localparam int TRAP_BIT  = 15;

   // Implemented bits; 13 down to 9 read as zero
   localparam logic [15:0] CAUSE_MASK  = 16'hC1FF;
   // Value after power-on: power-on and brown-out flags set
   localparam logic [15:0] CAUSE_RESET = 16'h0003;
   // Flags kept through a power-on event
   localparam logic [15:0] POR_KEEP    = 16'h0001;

   // Number of reset sources
   localparam int NUM_SRC = 7;

   // Source indices in the request vector
   localparam int SRC_POR  = 0;
   localparam int SRC_BOR  = 1;
   localparam int SRC_PIN  = 2;
   localparam int SRC_SWR  = 3;
   localparam int SRC_WDT  = 4;
   localparam int SRC_TRAP = 5;
   localparam int SRC_ILL  = 6;

   // Events that share the illegal-condition flag
   typedef struct packed {
      logic opcode;
      logic w_uninit;
      logic security;
   } rsc_illegal_t;

   // Wake events from low power modes
   typedef struct packed {
      logic sleep;
      logic idle;
   } rsc_wake_t;

endpackage : rsc_pkg

// ---- rsc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser, one per bit
module rsc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Elaboration guard against a zero-width bus
   if (WIDTH < 1) begin : g_bad_width
      $error("rsc_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;

endmodule : rsc_sync

`default_nettype wire

// ---- rsc_combine.sv ----
`timescale 1ns/1ps
`default_nettype none

// OR of all reset requests and rising-edge pulses per source
module rsc_combine #(
   parameter int NUM = 7
) (
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire logic [NUM-1:0] req_i,
   output logic                any_o,
   output logic      [NUM-1:0] rise_o
);

   logic [NUM-1:0] prev_q;

   // Elaboration guard: an empty source vector has nothing to combine
   if (NUM < 1) begin : g_bad_num
      $error("rsc_combine: NUM must be at least 1");
   end

   // Previous levels for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= '0;
      end else begin
         prev_q <= req_i;
      end
   end

   // One flag event per source assertion
   genvar g;
   for (g = 0; g < NUM; g = g + 1) begin : g_edge
      assign rise_o[g] = req_i[g] & ~prev_q[g];
   end

   assign any_o = |req_i;

endmodule : rsc_combine

`default_nettype wire

// ---- rsc_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

// ***************************************************
// Port checker for the reset combiner
// ***************************************************
module rsc_top_asserts (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [3:0]            wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire logic                  wb_err_o,
   input wire logic                  por_req_i,
   input wire logic                  brownout_req_i,
   input wire logic                  master_clear_pin_n_i,
   input wire logic                  soft_reset_req_i,
   input wire logic                  watchdog_timeout_i,
   input wire logic                  trap_conflict_i,
   input wire rsc_pkg::rsc_illegal_t illegal_i,
   input wire logic                  watchdog_fuse_enable_i,
   input wire logic                  master_reset_out_o,
   input wire logic                  watchdog_enable_o,
   input wire logic                  regulator_sleep_active_o
);
   // Bus take, cause write and live same-domain sources
   wire take_w = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire wr0_w  = take_w && wb_we_i && wb_adr_i == 4'h0;
   wire src_w  = por_req_i || brownout_req_i || soft_reset_req_i || watchdog_timeout_i
                 || trap_conflict_i || (|illegal_i);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   bus_answer_a: assert property (take_w |=> wb_ack_o != wb_err_o) else $error("no bus answer");
   unmapped_err_a: assert property (take_w && !(wb_adr_i inside {4'h0, 4'h4, 4'h8})
      |=> wb_err_o) else $error("unmapped not refused");
   any_source_a: assert property (src_w |=> master_reset_out_o) else $error("reset missed");
   pin_reset_a: assert property (!master_clear_pin_n_i [*3] |=> master_reset_out_o)
      else $error("pin reset missed");
   // Sync delay of the pin covered by four quiet cycles
   quiet_release_a: assert property ((!src_w && master_clear_pin_n_i) [*4]
      |=> !master_reset_out_o) else $error("reset without source");
   unimpl_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0
      |-> (wb_dat_o & ~{16'h0, rsc_pkg::CAUSE_MASK}) == 32'h0) else $error("bad read bits");
   regulator_write_a: assert property (wr0_w && wb_sel_i[1]
      |=> regulator_sleep_active_o == $past(wb_dat_i[8])) else $error("regulator bit");
   wdt_soft_a: assert property (wr0_w && wb_sel_i[0] && wb_dat_i[5] |=> watchdog_enable_o)
      else $error("soft watchdog enable");
   wdt_fuse_a: assert property (watchdog_fuse_enable_i [*3] |=> watchdog_enable_o)
      else $error("fuse watchdog enable");
   cover property (wr0_w);
   cover property (take_w && wb_adr_i == 4'hC);
   cover property ($rose(trap_conflict_i));
endmodule : rsc_top_asserts

bind rsc_top rsc_top_asserts u_asserts (.*);

`default_nettype wire

// ---- reset_source_combiner_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// ***************************************************
// Bench: bus tasks and source sweeps
// ***************************************************
module reset_source_combiner_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic [3:0]  adr   = 4'h0;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic        por   = 1'b0;
   logic        fuse  = 1'b0;
   logic [9:0]  src   = 10'h0;
   logic [31:0] rdat, rd;
   logic        ack, err, e, mro, wdte, vreg;
   logic [15:0] exp_q;
   int          n_mismatch = 0;
   int          n_tests    = 0;
   // Cause flag per source bit: brown-out, pin, soft, wdt, trap, 3 illegal, idle, sleep
   localparam logic [15:0] FLAG [10] = '{16'h0002, 16'h0080, 16'h0040, 16'h0010, 16'h8000,
                                         16'h4000, 16'h4000, 16'h4000, 16'h0004, 16'h0008};

   rsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .por_req_i(por), .brownout_req_i(src[0]),
      .master_clear_pin_n_i(!src[1]), .soft_reset_req_i(src[2]), .watchdog_timeout_i(src[3]),
      .trap_conflict_i(src[4]), .illegal_i(src[7:5]), .wake_i(src[9:8]),
      .watchdog_fuse_enable_i(fuse), .master_reset_out_o(mro), .watchdog_enable_o(wdte),
      .regulator_sleep_active_o(vreg));

   initial forever #5 clk_i = ~clk_i;

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : check

   // Classic cycle; held until ack or err, bounded so a dead slave ends the run
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic er);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= s;
      do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1 && ++k < 50);
      q = rdat;
      er = err;
      cyc <= 1'b0;
      we <= 1'b0;
      // A dead slave counts as a mismatch and ends the run
      if (k >= 50) begin
         n_mismatch++;
         summarize();
      end
   endtask : bus

   initial begin
      repeat (10) @(posedge clk_i);
      check("reset out in reset", 32'h1, mro);
      rst_i <= 1'b0;
      bus(1'b0, 4'h0, 32'h0, 4'h3, rd, e);
      check("power-on value", 32'h0003, rd);
      // Clear after reading so the next cause stands alone
      bus(1'b1, 4'h0, 32'h0, 4'h3, rd, e);
      check("write no reset", 32'h0, mro);
      exp_q = 16'h0;
      // Flags accumulate; later events must not wipe earlier ones
      for (int i = 0; i < 10; i++) begin
         src <= 10'h1 << i;
         repeat (4) @(posedge clk_i);
         check("master reset", 32'(i < 8), mro);
         src <= 10'h0;
         exp_q = exp_q | FLAG[i];
         bus(1'b0, 4'h0, 32'h0, 4'h3, rd, e);
         check("cause", {16'h0, exp_q}, rd);
      end
      bus(1'b1, 4'h0, 32'hFFFF, 4'h3, rd, e);
      check("soft wdt on", 32'h1, wdte);
      bus(1'b0, 4'h0, 32'h0, 4'h3, rd, e);
      check("all ones", {16'h0, rsc_pkg::CAUSE_MASK}, rd);
      check("regulator on", 32'h1, vreg);
      bus(1'b1, 4'h0, 32'h0, 4'h1, rd, e);
      bus(1'b0, 4'h0, 32'h0, 4'h3, rd, e);
      check("low lane clear", 32'hC100, rd);
      check("soft wdt off", 32'h0, wdte);
      fuse <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("fuse wdt on", 32'h1, wdte);
      src <= 10'h010;
      bus(1'b0, 4'h4, 32'h0, 4'h3, rd, e);
      check("live sources", 32'h20, rd);
      src <= 10'h0;
      por <= 1'b1;
      @(posedge clk_i);
      por <= 1'b0;
      repeat (4) @(posedge clk_i);
      bus(1'b0, 4'h0, 32'h0, 4'h3, rd, e);
      check("after power-on", 32'h0001, rd);
      check("regulator standby", 32'h0, vreg);
      // Watchdog edge lands on the clearing write's take edge: the set must win
      fork
         bus(1'b1, 4'h0, 32'h0, 4'h3, rd, e);
         begin
            @(posedge clk_i);
            src <= 10'h008;
         end
      join
      src <= 10'h0;
      bus(1'b0, 4'h0, 32'h0, 4'h3, rd, e);
      check("set beats clear", 32'h0010, rd);
      // Spare control byte round trip
      bus(1'b1, 4'h8, 32'h000000A5, 4'h1, rd, e);
      bus(1'b0, 4'h8, 32'h0, 4'h3, rd, e);
      check("control byte", 32'h000000A5, rd);
      bus(1'b0, 4'hC, 32'h0, 4'h3, rd, e);
      check("unmapped err", 32'h1, e);
      summarize();
   end
endmodule : reset_source_combiner_tb_top

`default_nettype wire
